//--- rtl/nand_host.sv
// Function
// RULE_01 - Send 24 address bits as column, low row, high row byte cycles.
// RULE_02 - Register half chosen by read code 00h low half, 01h high half.
// RULE_03 - Device drops surplus address cycles; host sends exactly the needed count.
// RULE_04 - 65,536 pages of 528 columns; columns 512 to 527 are spare.
// RULE_05 - Device page buffer of 528 bytes carries all page transfers.
// RULE_06 - Read and program by page; erase only by whole 16K-Byte block.
// RULE_07 - Write strobe pulses low under chip select; byte taken at rising edge.
// RULE_08 - Command latch high marks a command, address latch high an address.
// RULE_09 - Reset, reads and status read are single command cycles.
// RULE_10 - Program, copy-back and erase use a setup code then an execute code.
// RULE_11 - Page read and program get all three address cycles after the command.
// RULE_12 - Erase is 60h, two row cycles, then D0h.
// RULE_13 - Read codes 00h/01h, 50h and identify 90h select their operations.
// RULE_14 - Program is 80h, address, data bytes, then 10h.
// RULE_15 - Copy-back is 00h then 8Ah; never issued on the low-voltage part.
// RULE_16 - While busy only FFh and 70h may be issued.
// RULE_17 - Only codes of the defined command set are ever issued.
// RULE_18 - Ready/busy is low during program, erase or page read.
// RULE_19 - Each read strobe fall yields the next byte and advances the column.
// RULE_20 - Wait for ready before any non-status command after a busy operation. The host also lets reset (FFh) through while busy.
// RULE_21 - Device floats the byte bus unless selected and read strobe is active.
`timescale 1ns/1ps
`include "nand_host_map.svh"
module nand_host (
    input wire logic clk,
    input wire logic resetn,
    input nand_host_pkg::req_type req,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic done,
    output logic error,
    output logic busy,
    input wire logic copyback_enable,
    input wire logic write_allow,
    output nand_host_pkg::pins_type pins,
    input wire logic [7:0] io_in,
    input wire logic rb_n
);
    nand_host_pkg::ctl_type s_r;
    nand_host_pkg::ctl_type s_nxt;
    logic tick;
    logic buf_in_valid;
    logic buf_in_ready;
    logic low_prio_ok;

    // Opening code; the op enum has no path to an undefined code
    function automatic logic [7:0] first_code(nand_host_pkg::req_type r);
        unique case (r.op)
            nand_host_pkg::OP_READ: return r.register_half_select ? `NH_CMD_READ_HIGH : `NH_CMD_READ_LOW; // RULE_02
            nand_host_pkg::OP_READ_SPARE: return `NH_CMD_READ_SPARE; // RULE_13
            nand_host_pkg::OP_IDENTIFY: return `NH_CMD_IDENTIFY; // RULE_13
            nand_host_pkg::OP_STATUS: return `NH_CMD_STATUS;
            nand_host_pkg::OP_RESET: return `NH_CMD_RESET;
            nand_host_pkg::OP_PROGRAM: return `NH_CMD_PROG_SETUP; // RULE_14
            nand_host_pkg::OP_COPYBACK: return `NH_CMD_COPY_SETUP; // RULE_15
            nand_host_pkg::OP_ERASE: return `NH_CMD_ERASE_SETUP; // RULE_12
        endcase
    endfunction

    function automatic logic [1:0] addr_count(nand_host_pkg::op_type op);
        unique case (op)
            nand_host_pkg::OP_ERASE: return `NH_ADDR_ROW; // RULE_06
            nand_host_pkg::OP_IDENTIFY: return `NH_ADDR_ID;
            nand_host_pkg::OP_STATUS, nand_host_pkg::OP_RESET: return `NH_ADDR_NONE; // RULE_09
            default: return `NH_ADDR_FULL; // RULE_11
        endcase
    endfunction

    // Byte order column, low row, high row; erase skips the column
    function automatic logic [7:0] addr_byte(nand_host_pkg::req_type r, logic ph, logic [1:0] i);
        logic [15:0] row;
        logic [1:0] k;
        row = ph ? r.dest : r.row;
        k = (r.op == nand_host_pkg::OP_ERASE) ? 2'(i + 2'h1) : i; // RULE_12
        unique case (k)
            2'h0: return ph ? `NH_COL_ZERO : r.col; // RULE_01
            2'h1: return row[7:0];
            default: return row[15:8]; // RULE_04
        endcase
    endfunction

    assign tick = (s_r.tmr == 8'(`NH_PHASE_CYC - 1));
    assign low_prio_ok = (req.op == nand_host_pkg::OP_RESET) || (req.op == nand_host_pkg::OP_STATUS);
    assign req_ready = (s_r.st == nand_host_pkg::S_IDLE) && (s_r.rb || low_prio_ok); // RULE_16 RULE_20
    assign wr_ready = (s_r.st == nand_host_pkg::S_WR) && !s_r.loaded;
    assign buf_in_valid = (s_r.st == nand_host_pkg::S_RD) && tick && !s_r.pins.read_strobe_n; // RULE_19
    assign pins = s_r.pins;
    assign done = s_r.done;
    assign error = s_r.error;
    assign busy = (s_r.st != nand_host_pkg::S_IDLE);

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'h0;
        s_nxt.error = 1'h0;
        s_nxt.pins.wp_n = write_allow;
        // Three-stage sync; a level counts once stages two and three agree
        s_nxt.rb_ff = {s_r.rb_ff[1:0], rb_n};
        if (s_r.rb_ff[1] == s_r.rb_ff[2])
            s_nxt.rb = s_r.rb_ff[2];
        s_nxt.io_ff1 = io_in;
        s_nxt.io_ff2 = s_r.io_ff1;
        s_nxt.io_ff3 = s_r.io_ff2;
        if (s_r.io_ff2 == s_r.io_ff3)
            s_nxt.io_val = s_r.io_ff3;
        s_nxt.tmr = tick ? 8'h00 : 8'(s_r.tmr + 8'h01);
        unique case (s_r.st)
            nand_host_pkg::S_IDLE:
            begin
                s_nxt.tmr = 8'h00;
                s_nxt.pins.ce_n = 1'h1;
                s_nxt.pins.io_oe = 1'h0;
                if (req_valid && req_ready)
                begin
                    s_nxt.req = req;
                    s_nxt.ph = 1'h0;
                    s_nxt.acnt = 2'h0;
                    s_nxt.cnt = 10'h000;
                    s_nxt.loaded = 1'h0;
                    if (req.op == nand_host_pkg::OP_COPYBACK && !copyback_enable)
                        s_nxt.error = 1'h1; // RULE_15
                    else
                    begin
                        s_nxt.st = nand_host_pkg::S_CMD1;
                        s_nxt.pins.ce_n = 1'h0;
                        s_nxt.pins.cle = 1'h1; // RULE_08
                        s_nxt.pins.io_out = first_code(req); // RULE_17
                        s_nxt.pins.io_oe = 1'h1;
                    end
                end
            end
            nand_host_pkg::S_CMD1, nand_host_pkg::S_ADDR, nand_host_pkg::S_WR, nand_host_pkg::S_CMD2:
            begin
                if (s_r.st == nand_host_pkg::S_WR && !s_r.loaded)
                begin
                    s_nxt.tmr = 8'h00;
                    if (wr_valid)
                    begin
                        s_nxt.pins.io_out = wr_data;
                        s_nxt.loaded = 1'h1;
                    end
                end
                else if (tick && !s_r.strobed)
                begin
                    s_nxt.pins.we_n = !s_r.pins.we_n; // RULE_07
                    s_nxt.strobed = !s_r.pins.we_n;
                end
                else if (tick)
                begin
                    s_nxt.strobed = 1'h0;
                    if (s_r.pins.we_n)
                    begin
                        // Byte held one phase past the rise, so the flash never sees it move
                        unique case (s_r.st)
                            nand_host_pkg::S_CMD1:
                            begin
                                s_nxt.pins.cle = 1'h0;
                                if (addr_count(s_r.req.op) != `NH_ADDR_NONE)
                                begin
                                    s_nxt.st = nand_host_pkg::S_ADDR;
                                    s_nxt.pins.ale = 1'h1; // RULE_08
                                    s_nxt.pins.io_out = addr_byte(s_r.req, 1'h0, 2'h0);
                                end
                                else if (s_r.req.op == nand_host_pkg::OP_RESET)
                                begin
                                    s_nxt.st = nand_host_pkg::S_WAIT;
                                    s_nxt.cnt = 10'h000;
                                    s_nxt.waited = 1'h0;
                                end
                                else
                                begin
                                    s_nxt.st = nand_host_pkg::S_RD; // RULE_09
                                    s_nxt.cnt = 10'h000;
                                end
                            end
                            nand_host_pkg::S_ADDR:
                            begin
                                s_nxt.acnt = 2'(s_r.acnt + 2'h1);
                                s_nxt.pins.io_out = addr_byte(s_r.req, s_r.ph, 2'(s_r.acnt + 2'h1));
                                if (2'(s_r.acnt + 2'h1) == addr_count(s_r.req.op)) // RULE_03
                                begin
                                    s_nxt.pins.ale = 1'h0;
                                    s_nxt.cnt = 10'h000;
                                    s_nxt.waited = 1'h0;
                                    unique case (s_r.req.op)
                                        nand_host_pkg::OP_IDENTIFY: s_nxt.st = nand_host_pkg::S_RD;
                                        nand_host_pkg::OP_PROGRAM: s_nxt.st = nand_host_pkg::S_WR; // RULE_05
                                        nand_host_pkg::OP_ERASE:
                                        begin
                                            s_nxt.st = nand_host_pkg::S_CMD2;
                                            s_nxt.pins.cle = 1'h1;
                                            s_nxt.pins.io_out = `NH_CMD_ERASE_GO; // RULE_12
                                        end
                                        default: s_nxt.st = nand_host_pkg::S_WAIT;
                                    endcase
                                end
                            end
                            nand_host_pkg::S_WR:
                            begin
                                s_nxt.loaded = 1'h0;
                                s_nxt.cnt = 10'(s_r.cnt + 10'h001);
                                if (10'(s_r.cnt + 10'h001) == s_r.req.len)
                                begin
                                    s_nxt.st = nand_host_pkg::S_CMD2;
                                    s_nxt.pins.cle = 1'h1;
                                    s_nxt.pins.io_out = `NH_CMD_PROG_GO; // RULE_14
                                end
                            end
                            default:
                            begin
                                s_nxt.pins.cle = 1'h0;
                                s_nxt.cnt = 10'h000;
                                s_nxt.waited = 1'h0;
                                if (s_r.req.op == nand_host_pkg::OP_COPYBACK)
                                begin
                                    s_nxt.st = nand_host_pkg::S_ADDR; // RULE_10
                                    s_nxt.ph = 1'h1;
                                    s_nxt.acnt = 2'h0;
                                    s_nxt.pins.ale = 1'h1;
                                    s_nxt.pins.io_out = addr_byte(s_r.req, 1'h1, 2'h0);
                                end
                                else
                                    s_nxt.st = nand_host_pkg::S_WAIT;
                            end
                        endcase
                        if (s_nxt.st == nand_host_pkg::S_RD || s_nxt.st == nand_host_pkg::S_WAIT)
                            s_nxt.pins.io_oe = 1'h0;
                    end
                end
            end
            nand_host_pkg::S_WAIT:
            begin
                // Ready/busy only falls some time after the last strobe
                if (!s_r.waited)
                begin
                    s_nxt.cnt = 10'(s_r.cnt + 10'h001);
                    if (s_r.cnt == 10'(`NH_BUSY_ONSET_CYC - 1))
                        s_nxt.waited = 1'h1;
                end
                else if (s_r.rb) // RULE_18
                begin
                    s_nxt.cnt = 10'h000;
                    s_nxt.tmr = 8'h00;
                    unique case (s_r.req.op)
                        nand_host_pkg::OP_READ, nand_host_pkg::OP_READ_SPARE: s_nxt.st = nand_host_pkg::S_RD;
                        nand_host_pkg::OP_COPYBACK:
                        begin
                            if (s_r.ph)
                                s_nxt.st = nand_host_pkg::S_DONE;
                            else
                            begin
                                s_nxt.st = nand_host_pkg::S_CMD2;
                                s_nxt.pins.cle = 1'h1;
                                s_nxt.pins.io_out = `NH_CMD_COPY_GO; // RULE_15
                                s_nxt.pins.io_oe = 1'h1;
                            end
                        end
                        default: s_nxt.st = nand_host_pkg::S_DONE;
                    endcase
                end
            end
            nand_host_pkg::S_RD:
            begin
                s_nxt.pins.io_oe = 1'h0; // RULE_21
                // Never start a strobe that the buffer could not take
                if (s_r.pins.read_strobe_n && s_r.tmr == 8'h00 && !buf_in_ready)
                    s_nxt.tmr = 8'h00;
                else if (tick)
                begin
                    s_nxt.pins.read_strobe_n = !s_r.pins.read_strobe_n; // RULE_19
                    if (!s_r.pins.read_strobe_n)
                    begin
                        s_nxt.cnt = 10'(s_r.cnt + 10'h001);
                        if (10'(s_r.cnt + 10'h001) == s_r.req.len)
                            s_nxt.st = nand_host_pkg::S_DONE;
                    end
                end
            end
            nand_host_pkg::S_DONE:
            begin
                s_nxt.pins.ce_n = 1'h1;
                s_nxt.done = 1'h1;
                s_nxt.st = nand_host_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            s_r <= '0;
            s_r.pins.ce_n <= 1'h1;
            s_r.pins.we_n <= 1'h1;
            s_r.pins.read_strobe_n <= 1'h1;
        end
        else
            s_r <= s_nxt;
    end

    // Read bytes wait here so a stalled consumer loses nothing
    pair_buffer #(.WIDTH(8)) read_buf (
        .clk(clk),
        .resetn(resetn),
        .in_data(s_r.io_val),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .out_data(rd_data),
        .out_valid(rd_valid),
        .out_ready(rd_ready)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_latch_exclusive: assert property (!(pins.cle && pins.ale)) else $error("cle and ale both high"); // RULE_08
    a_we_selected: assert property (!pins.we_n |-> !pins.ce_n) else $error("write strobe without select"); // RULE_07
    a_we_width: assert property ($fell(pins.we_n) |-> (!pins.we_n)[*5] ##1 pins.we_n) // RULE_07
        else $error("write strobe low width wrong");
    a_we_data_hold: assert property (!pins.we_n |=> pins.we_n || $stable(pins.io_out)) // RULE_07
        else $error("bus changed under write strobe");
    a_read_no_drive: assert property (!pins.read_strobe_n |-> !pins.io_oe) else $error("bus driven during read"); // RULE_21
    a_busy_refuse: assert property (pins.cle && !s_r.rb
        |-> pins.io_out == `NH_CMD_RESET || pins.io_out == `NH_CMD_STATUS) // RULE_16
        else $error("command issued while busy");
    a_erase_confirm: assert property (s_r.st == nand_host_pkg::S_CMD2 && s_r.req.op == nand_host_pkg::OP_ERASE
        |-> pins.io_out == `NH_CMD_ERASE_GO && pins.cle) else $error("erase confirm code wrong"); // RULE_12
    a_prog_confirm: assert property (s_r.st == nand_host_pkg::S_CMD2 && s_r.req.op == nand_host_pkg::OP_PROGRAM
        |-> pins.io_out == `NH_CMD_PROG_GO) else $error("program confirm code wrong"); // RULE_14
    a_wait_busy: assert property (s_r.st == nand_host_pkg::S_WAIT && s_r.waited && !s_r.rb
        |=> s_r.st == nand_host_pkg::S_WAIT) else $error("left wait while busy"); // RULE_18
    a_copy_gate: assert property (req_valid && req_ready && req.op == nand_host_pkg::OP_COPYBACK && !copyback_enable
        |=> s_r.st == nand_host_pkg::S_IDLE && error) else $error("copy-back not refused"); // RULE_15

    c_program: cover property (s_r.st == nand_host_pkg::S_CMD2 && s_r.req.op == nand_host_pkg::OP_PROGRAM ##[1:120] done);
    c_read_stall: cover property (s_r.st == nand_host_pkg::S_RD && !buf_in_ready);
    c_erase: cover property (s_r.req.op == nand_host_pkg::OP_ERASE && done);
    c_copyback: cover property (s_r.req.op == nand_host_pkg::OP_COPYBACK && s_r.ph && done);
endmodule

//--- rtl/nand_host_map.svh
`ifndef NAND_HOST_MAP_SVH
`define NAND_HOST_MAP_SVH

// Command codes of the flash
`define NH_CMD_READ_LOW 8'h00
`define NH_CMD_READ_HIGH 8'h01
`define NH_CMD_READ_SPARE 8'h50
`define NH_CMD_IDENTIFY 8'h90
`define NH_CMD_RESET 8'hFF
`define NH_CMD_PROG_SETUP 8'h80
`define NH_CMD_PROG_GO 8'h10
`define NH_CMD_COPY_SETUP 8'h00
`define NH_CMD_COPY_GO 8'h8A
`define NH_CMD_ERASE_SETUP 8'h60
`define NH_CMD_ERASE_GO 8'hD0
`define NH_CMD_STATUS 8'h70

// Address cycle counts
`define NH_ADDR_FULL 2'h3
`define NH_ADDR_ROW 2'h2
`define NH_ADDR_ID 2'h1
`define NH_ADDR_NONE 2'h0

// Page geometry
`define NH_PAGE_BYTES 10'h210
`define NH_COL_ZERO 8'h00

// Timing: clock period and strobe phase, busy onset delay
`define NH_CLK_NS 5
`define NH_STROBE_NS 25
`define NH_PHASE_CYC ((`NH_STROBE_NS + `NH_CLK_NS - 1) / `NH_CLK_NS)
`define NH_BUSY_ONSET_NS 100
`define NH_BUSY_ONSET_CYC ((`NH_BUSY_ONSET_NS + `NH_CLK_NS - 1) / `NH_CLK_NS)

`endif

//--- rtl/nand_host_pkg.sv
package nand_host_pkg;

    typedef enum logic [2:0] {
        OP_READ, OP_READ_SPARE, OP_IDENTIFY, OP_STATUS,
        OP_RESET, OP_PROGRAM, OP_COPYBACK, OP_ERASE
    } op_type;

    typedef struct packed {
        op_type op;
        logic register_half_select;
        logic [7:0] col;
        logic [15:0] row;
        logic [15:0] dest;
        logic [9:0] len;
    } req_type;

    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic read_strobe_n;
        logic wp_n;
        logic [7:0] io_out;
        logic io_oe;
    } pins_type;

    typedef enum logic [2:0] {S_IDLE, S_CMD1, S_ADDR, S_WR, S_CMD2, S_WAIT, S_RD, S_DONE} st_type;

    typedef struct packed {
        st_type st;
        req_type req;
        logic ph;
        logic [1:0] acnt;
        logic [9:0] cnt;
        logic [7:0] tmr;
        logic loaded;
        logic waited;
        logic strobed;
        pins_type pins;
        logic [2:0] rb_ff;
        logic rb;
        logic [7:0] io_ff1;
        logic [7:0] io_ff2;
        logic [7:0] io_ff3;
        logic [7:0] io_val;
        logic done;
        logic error;
    } ctl_type;

endpackage

//--- rtl/pair_buffer.sv
`timescale 1ns/1ps
module pair_buffer #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    typedef struct packed {
        logic [WIDTH-1:0] e0;
        logic [WIDTH-1:0] e1;
        logic [1:0] n;
    } buf_type;

    buf_type s_r;
    buf_type s_nxt;
    logic push;
    logic pop;
    logic [1:0] slot;

    assign in_ready = (s_r.n != 2'h2);
    assign out_valid = (s_r.n != 2'h0);
    assign out_data = s_r.e0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        s_nxt = s_r;
        slot = s_r.n;
        if (pop)
        begin
            s_nxt.e0 = s_r.e1;
            slot = 2'(s_r.n - 2'h1);
        end
        if (push)
        begin
            if (slot == 2'h0)
                s_nxt.e0 = in_data;
            else
                s_nxt.e1 = in_data;
        end
        s_nxt.n = 2'(slot + {1'h0, push});
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
endmodule

//--- verif/flash_model.sv
`timescale 1ns/1ps
module flash_model #(
    parameter logic [7:0] ID0 = 8'h5A,
    parameter logic [7:0] ID1 = 8'hA5
) (
    input nand_host_pkg::pins_type pins,
    output logic [7:0] io_in,
    output logic rb_n
);
    logic [7:0] mem [int];
    logic [7:0] pbuf [528];
    logic [7:0] cmd = 8'hFF;
    logic [7:0] dout = 8'h00;
    logic [7:0] io;
    logic cpy = 1'b0;
    int acnt = 0;
    int col = 0;
    int row = 0;
    initial rb_n = 1'b1;
    // Undriven bus shows inverse of last byte, not a stale copy
    assign io_in = (!pins.ce_n && !pins.read_strobe_n) ? dout : ~dout;
    task automatic go_busy(int ns);
        rb_n <= #10 1'b0;
        rb_n <= #(10 + ns) 1'b1;
    endtask
    always @(posedge pins.we_n) if (!pins.ce_n)
    begin
        io = pins.io_out;
        if (pins.cle && (rb_n || io == 8'hFF || io == 8'h70))
        begin
            acnt = 0;
            case (io)
                8'h80: begin cmd = io; foreach (pbuf[i]) pbuf[i] = 8'hFF; end
                8'h10: begin foreach (pbuf[i]) mem[row * 528 + i] = pbuf[i]; go_busy(300); end
                8'h8A: cpy = 1'b1;
                8'hD0: begin for (int i = 0; i < 32 * 528; i++) mem.delete((row & ~31) * 528 + i); go_busy(300); end
                8'hFF: begin cmd = io; cpy = 1'b0; go_busy(50); end
                default: cmd = io;
            endcase
        end
        else if (pins.ale)
        begin
            acnt++;
            if (cmd == 8'h60 && acnt <= 2) row[8 * acnt - 8 +: 8] = io;
            else if (cmd != 8'h60 && acnt == 1) col = cmd == 8'h01 ? 256 + io : cmd == 8'h50 ? 512 + io[3:0] : io;
            else if (cmd != 8'h60 && acnt <= 3) row[8 * acnt - 16 +: 8] = io;
            if (acnt == 3 && (cmd == 8'h00 || cmd == 8'h01 || cmd == 8'h50))
            begin
                foreach (pbuf[i])
                    if (cpy) mem[row * 528 + i] = pbuf[i];
                    else pbuf[i] = mem.exists(row * 528 + i) ? mem[row * 528 + i] : 8'hFF;
                cpy = 1'b0;
                go_busy(300);
            end
        end
        else if (cmd == 8'h80 && col < 528) begin pbuf[col] = io; col++; end
    end
    always @(negedge pins.read_strobe_n) if (!pins.ce_n)
    begin
        dout = cmd == 8'h70 ? {pins.wp_n, rb_n, 6'h00} : cmd == 8'h90 ? (col == 0 ? ID0 : ID1) : pbuf[col % 528];
        col++;
    end
endmodule

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] MAKER_ID = 8'h5A; // Arbitrary value
    localparam logic [7:0] PART_ID = 8'hA5; // Arbitrary value
    logic clk = 1'b0;
    logic resetn = 1'b0;
    nand_host_pkg::req_type req = '0;
    logic req_valid = 0, wr_valid = 0, rd_ready = 0, copyback_enable = 0, write_allow = 1, took = 0, rtook = 0;
    logic req_ready, wr_ready, rd_valid, done, error, busy, rb_n;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] rd_data, io_in;
    nand_host_pkg::pins_type pins;
    int mismatches = 0;
    int cmp_count = 0;
    logic [31:0] rs = 32'd71;
    logic [7:0] ref_mem [int];
    logic [7:0] exp_q [$];
    logic [7:0] wq [$];
    logic [7:0] c;
    logic [15:0] r;
    always #2.5 clk = ~clk;
    nand_host i_dut (.clk(clk), .resetn(resetn), .req(req), .req_valid(req_valid), .req_ready(req_ready),
        .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .done(done), .error(error), .busy(busy), .copyback_enable(copyback_enable),
        .write_allow(write_allow), .pins(pins), .io_in(io_in), .rb_n(rb_n));
    flash_model #(.ID0(MAKER_ID), .ID1(PART_ID)) i_flash (.pins(pins), .io_in(io_in), .rb_n(rb_n));
    function automatic logic [7:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[7:0];
    endfunction
    function automatic logic [7:0] rref(int k);
        return ref_mem.exists(k) ? ref_mem[k] : 8'hFF;
    endfunction
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (e !== g)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        took <= wr_valid && wr_ready;
        rtook <= req_valid && req_ready;
        if (rd_valid && rd_ready) chk("rd_data", exp_q.size() != 0 ? exp_q.pop_front() : 8'hXX, rd_data);
    end
    // Consumer stalls at random to push back through the two-entry buffer
    always @(negedge clk)
    begin
        rd_ready <= rnd() > 8'h50;
        if (took) void'(wq.pop_front());
        wr_valid <= wq.size() != 0;
        wr_data <= wq.size() != 0 ? wq[0] : 8'h00;
    end
    task automatic op(nand_host_pkg::op_type o, logic h, logic [7:0] cc, logic [15:0] rr, int n, logic err);
        int t;
        t = 0;
        @(negedge clk);
        req <= '{o, h, cc, rr, rr + 16'h0040, n[9:0]};
        req_valid <= 1'b1;
        do @(negedge clk); while (rtook !== 1'b1 && ++t < 20000);
        req_valid <= 1'b0;
        chk("busy", {7'h00, !err}, {7'h00, busy});
        while ((err ? error : done) !== 1'b1 && ++t < 20000) @(negedge clk);
        chk("op_end", 8'h00, {7'h00, t >= 20000});
    endtask
    task automatic rd(nand_host_pkg::op_type o, logic h, logic [7:0] cc, logic [15:0] rr, int n, int base);
        for (int i = 0; i < n; i++) exp_q.push_back(rref(rr * 528 + base + i));
        op(o, h, cc, rr, n, 1'b0);
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        @(negedge clk) resetn <= 1'b1;
        op(nand_host_pkg::OP_RESET, 0, 8'h00, 16'h0000, 1, 0);
        c = rnd() & 8'h0F;
        r = {rnd() & 8'h7F, rnd()};
        for (int i = 0; i < 6; i++)
        begin
            wq.push_back(rnd());
            ref_mem[r * 528 + c + i] = wq[i];
        end
        op(nand_host_pkg::OP_PROGRAM, 0, c, r, 6, 0);
        rd(nand_host_pkg::OP_READ, 0, c, r, 6, c);
        rd(nand_host_pkg::OP_READ, 1, 8'hFE, r, 4, 510);
        rd(nand_host_pkg::OP_READ_SPARE, 0, 8'h03, r, 4, 515);
        exp_q.push_back(MAKER_ID);
        exp_q.push_back(PART_ID);
        op(nand_host_pkg::OP_IDENTIFY, 0, 8'h00, r, 2, 0);
        write_allow <= 1'b0;
        exp_q.push_back(8'h40);
        exp_q.push_back(8'h40);
        op(nand_host_pkg::OP_STATUS, 0, 8'h00, r, 2, 0);
        write_allow <= 1'b1;
        op(nand_host_pkg::OP_COPYBACK, 0, 8'h00, r, 1, 1);
        copyback_enable <= 1'b1;
        for (int i = 0; i < 528; i++) ref_mem[(r + 64) * 528 + i] = rref(r * 528 + i);
        op(nand_host_pkg::OP_COPYBACK, 0, 8'h00, r, 1, 0);
        rd(nand_host_pkg::OP_READ, 0, c, r + 16'h0040, 6, c);
        op(nand_host_pkg::OP_ERASE, 0, 8'h00, r + 16'h0040, 1, 0);
        for (int i = 0; i < 32 * 528; i++) ref_mem.delete(((r + 64) & ~31) * 528 + i);
        rd(nand_host_pkg::OP_READ, 0, c, r + 16'h0040, 6, c);
        rd(nand_host_pkg::OP_READ, 0, c, r, 6, c);
        repeat (40) @(negedge clk);
        chk("rd_left", 8'h00, 8'(exp_q.size()));
        print_verdict();
    end
    initial
    begin
        #400000;
        mismatches++;
        print_verdict();
    end
endmodule
